// ---- logic/adcsm_pkg.sv ----
// constants and types shared by the status and mode register bank
package adcsm_pkg;
    // ************************************************************
    // register map, index times four gives the byte address
    // ************************************************************
    localparam int REG_W = 16;
    localparam int BUS_W = 32;
    localparam logic [7:0] IDX_IDENTITY = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_MODE = 8'h02;
    localparam logic [15:0] STATUS_RESET = 16'h0500;
    localparam logic [15:0] MODE_RESET = 16'h0510;
    localparam logic [15:0] MODE_WRITE_MASK = 16'h3F1F;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ID_COUNT_LSB = 8;
    localparam int ID_UPPER_LSB = 12;
    localparam int ST_LOCK = 15;
    localparam int ST_RESYNC = 14;
    localparam int ST_REGMAP = 13;
    localparam int ST_CRC_ERR = 12;
    localparam int ST_CRC_TYPE = 11;
    localparam int ST_RESET = 10;
    localparam int WLEN_LSB = 8;
    localparam int ST_CH1_NEW = 1;
    localparam int ST_CH0_NEW = 0;
    localparam int MD_REGCRC_EN = 13;
    localparam int MD_RXCRC_EN = 12;
    localparam int MD_CRC_TYPE = 11;
    localparam int MD_RESET = 10;
    localparam int MD_TIMEOUT = 4;
    localparam int MD_SRC_LSB = 2;
    localparam int MD_IDLE_FLOAT = 1;
    localparam int MD_PULSE_FMT = 0;
    // ************************************************************
    // checksum polynomials
    // ************************************************************
    localparam logic [15:0] POLY_CCITT = 16'h1021;
    localparam logic [15:0] POLY_ANSI = 16'h8005;
    localparam logic [15:0] CRC_SEED = 16'hFFFF;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 100;
    localparam int READY_PULSE_NS = 100;
    localparam int READY_PULSE_CYCLES = (READY_PULSE_NS * CLK_MHZ + 999) / 1000;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {WLEN_16, WLEN_24, WLEN_32_ZPAD, WLEN_32_SEXT} adcsm_wlen_t;
    typedef enum logic [1:0] {SRC_LAGGING, SRC_ANY, SRC_LEADING, SRC_LEADING_ALT} adcsm_src_t;
    typedef enum logic [1:0] {PIN_IDLE, PIN_HOLD, PIN_PULSE, PIN_DONE} adcsm_pin_state_t;
endpackage

// ---- logic/adcsm_ready_if.sv ----
// carrier between the register bank and the sample-ready pin driver
interface adcsm_ready_if #(parameter int NUM_CH = 2);
    logic [NUM_CH-1:0] pending;
    logic [NUM_CH-1:0] arrived;
    logic [NUM_CH-1:0] enabled;
    logic [1:0] source_select;
    logic idle_float;
    logic pulse_format;
    logic pin_level;
    logic pin_oe;
    modport bank (output pending, arrived, enabled, source_select, idle_float, pulse_format,
                  input pin_level, pin_oe);
    modport pin (input pending, arrived, enabled, source_select, idle_float, pulse_format,
                 output pin_level, pin_oe);
endinterface

// ---- logic/adcsm_ready_pin.sv ----
// sample-ready pin driver
module adcsm_ready_pin
    import adcsm_pkg::*;
#(
    parameter int PULSE_CYCLES = READY_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // carrier
    adcsm_ready_if.pin rdy
);
    import adcsm_pkg::*;

    localparam int CW = $clog2(PULSE_CYCLES + 1);
    adcsm_pin_state_t state, next_state;
    logic [CW-1:0] count, next_count;
    logic level, next_level;
    logic oe, next_oe;
    logic all_new, any_new, avail, retrigger;

    // ************************************************************
    // source selection
    // ************************************************************
    always_comb begin
        all_new = (&(rdy.pending | ~rdy.enabled)) && (|rdy.enabled);
        any_new = |(rdy.pending & rdy.enabled);
        retrigger = 1'b0;
        case (adcsm_src_t'(rdy.source_select))
            SRC_LAGGING: avail = all_new;
            SRC_ANY: begin
                avail = any_new;
                retrigger = |(rdy.arrived & rdy.enabled);
            end
            default: avail = any_new;
        endcase
    end

    // ************************************************************
    // pin sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            PIN_IDLE: begin
                if (avail) begin
                    next_state = rdy.pulse_format ? PIN_PULSE : PIN_HOLD;
                    next_count = CW'(PULSE_CYCLES);
                end
            end
            PIN_HOLD: begin
                if (!avail) begin
                    next_state = PIN_IDLE;
                end
            end
            PIN_PULSE: begin
                if (count <= CW'(1)) begin
                    next_state = PIN_DONE;
                end else begin
                    next_count = count - CW'(1);
                end
            end
            default: begin
                if (!avail) begin
                    next_state = PIN_IDLE;
                end else if (retrigger) begin
                    next_state = PIN_PULSE;
                    next_count = CW'(PULSE_CYCLES);
                end
            end
        endcase
        next_level = !(next_state == PIN_HOLD || next_state == PIN_PULSE);
        next_oe = !(next_level && rdy.idle_float);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= PIN_IDLE;
            count <= '0;
            level <= 1'b1;
            oe <= 1'b1;
        end else begin
            state <= next_state;
            count <= next_count;
            level <= next_level;
            oe <= next_oe;
        end
    end

    assign rdy.pin_level = level;
    assign rdy.pin_oe = oe;
endmodule

// ---- logic/adcsm_bank.sv ----
// identification, status and mode registers on an AHB-Lite slave
// ************************************************************
// top module
// ************************************************************
// Overview of operation
// - status bit 15 shows serial interface lock, 0 unlocked by default
// - status bit 14 sets on every converter resynchronisation
// - status bit 13 sets when the register map checksum changes
// - status bit 12 sets on an input word checksum error
// - status bit 11 shows the active polynomial, 0 CCITT, 1 ANSI
// - status bit 10 reads 1 after any reset
// - writing 0 to mode bit 10 clears status bit 10
// - status bits 9:8 show word length; 32-bit extended mode sign-extends
// - mode 9:8 selects 16, 24, 32 zero padded or 32 sign-extended words
// - status bit 1 shows new data on channel 1
// - status bit 0 shows new data on channel 0
// - register map checksum runs only while mode bit 13 is 1
// - input word checking runs only while mode bit 12 is 1
// - mode bit 11 picks the polynomial for every checksum
// - mode bit 4 enables the serial timeout, 1 after reset
// - mode 3:2 picks lagging, OR, or leading channel for the ready pin
// - idle ready pin is high, or floats when mode bit 1 is 1
// - new data hold the pin low, or pulse it low when bit 0 is 1
//
// Design decision made here: the AHB-Lite slave port.
module adcsm_bank
    import adcsm_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter logic [3:0] ID_UPPER = 4'h5,
    parameter logic [7:0] ID_REVISION = 8'hA3,
    parameter int PULSE_CYCLES = READY_PULSE_CYCLES
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [adcsm_pkg::BUS_W-1:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [adcsm_pkg::BUS_W-1:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [adcsm_pkg::BUS_W-1:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // converter and serial core events
    input wire logic LOCK_STATE_IN,
    input wire logic RESYNC_EVENT_IN,
    input wire logic RX_CRC_FAIL_IN,
    input wire logic [NUM_CH-1:0] NEW_SAMPLE_IN,
    input wire logic [NUM_CH-1:0] SAMPLE_TAKEN_IN,
    input wire logic [NUM_CH-1:0] CHANNEL_ENABLE_IN,
    input wire logic [23:0] CONV_DATA_IN,
    // configuration outputs
    output logic TIMEOUT_ENABLE_OUT,
    output logic RX_CRC_CHECK_OUT,
    output logic CRC_POLY_ANSI_OUT,
    output logic [1:0] WORD_SIZE_OUT,
    output logic [adcsm_pkg::BUS_W-1:0] FORMATTED_WORD_OUT,
    // sample-ready pin
    output logic SAMPLE_READY_OUT,
    output logic SAMPLE_READY_OE_OUT
);
    import adcsm_pkg::*;

    adcsm_ready_if #(.NUM_CH(NUM_CH)) rdy ();

    // ************************************************************
    // register state
    // ************************************************************
    logic [REG_W-1:0] mode, next_mode;
    logic lock_flag, next_lock_flag;
    logic resync_occurred_flag, next_resync_occurred_flag;
    logic regmap_flag, next_regmap_flag;
    logic crc_err_flag, next_crc_err_flag;
    logic reset_flag, next_reset_flag;
    logic [NUM_CH-1:0] new_sample_flag, next_new_sample_flag;
    logic [15:0] crc_last, next_crc_last;
    logic crc_valid, next_crc_valid;
    logic [BUS_W-1:0] word_out, next_word_out;

    // ************************************************************
    // bus state
    // ************************************************************
    logic dp_write, next_dp_write;
    logic [7:0] dp_index, next_dp_index;
    logic [BUS_W-1:0] rdata, next_rdata;
    logic addr_phase;
    logic [7:0] ap_index;
    logic [REG_W-1:0] identity_word;
    logic [REG_W-1:0] status_word;
    logic [REG_W-1:0] read_word;
    logic status_read;
    logic mode_write;
    logic [15:0] crc_now;

    function automatic logic [15:0] crc16_word(input logic [15:0] data, input logic ansi);
        logic [15:0] crc;
        logic [15:0] poly;
        crc = CRC_SEED;
        poly = ansi ? POLY_ANSI : POLY_CCITT;
        for (int i = 15; i >= 0; i--) begin
            if (crc[15] ^ data[i]) begin
                crc = {crc[14:0], 1'b0} ^ poly;
            end else begin
                crc = {crc[14:0], 1'b0};
            end
        end
        return crc;
    endfunction

    // ************************************************************
    // read data assembly
    // ************************************************************
    always_comb begin
        identity_word = '0;
        identity_word[ID_UPPER_LSB +: 4] = ID_UPPER; // arbitrary value
        identity_word[ID_COUNT_LSB +: 4] = 4'(NUM_CH);
        identity_word[7:0] = ID_REVISION;
        status_word = '0;
        status_word[ST_LOCK] = lock_flag;
        status_word[ST_RESYNC] = resync_occurred_flag;
        status_word[ST_REGMAP] = regmap_flag;
        status_word[ST_CRC_ERR] = crc_err_flag;
        status_word[ST_CRC_TYPE] = mode[MD_CRC_TYPE];
        status_word[ST_RESET] = reset_flag;
        status_word[WLEN_LSB +: 2] = mode[WLEN_LSB +: 2];
        status_word[ST_CH1_NEW] = new_sample_flag[1];
        status_word[ST_CH0_NEW] = new_sample_flag[0];
    end

    // ************************************************************
    // ahb-lite address and data phases
    // ************************************************************
    always_comb begin
        addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
        ap_index = HADDR_IN[9:2];
        read_word = '0;
        if (ap_index == IDX_IDENTITY) begin
            read_word = identity_word;
        end else if (ap_index == IDX_STATUS) begin
            read_word = status_word;
        end else if (ap_index == IDX_MODE) begin
            read_word = mode;
            read_word[MD_RESET] = reset_flag;
        end else begin
            read_word = '0;
        end
        if (HADDR_IN[BUS_W-1:10] != '0) begin
            read_word = '0;
        end
        next_dp_write = addr_phase && HWRITE_IN && (HADDR_IN[BUS_W-1:10] == '0);
        next_dp_index = addr_phase ? ap_index : dp_index;
        next_rdata = (addr_phase && !HWRITE_IN) ? {16'h0000, read_word} : rdata;
        status_read = addr_phase && !HWRITE_IN && (ap_index == IDX_STATUS)
                      && (HADDR_IN[BUS_W-1:10] == '0);
        mode_write = dp_write && (dp_index == IDX_MODE);
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dp_write <= 1'b0;
            dp_index <= 8'h00;
            rdata <= '0;
        end else begin
            dp_write <= next_dp_write;
            dp_index <= next_dp_index;
            rdata <= next_rdata;
        end
    end

    // ************************************************************
    // mode register and status flags
    // ************************************************************
    always_comb begin
        next_mode = mode;
        if (mode_write) begin
            next_mode = HWDATA_IN[REG_W-1:0] & MODE_WRITE_MASK;
        end
        next_lock_flag = LOCK_STATE_IN;
        next_resync_occurred_flag = resync_occurred_flag;
        if (status_read) begin
            next_resync_occurred_flag = 1'b0;
        end
        if (RESYNC_EVENT_IN) begin
            next_resync_occurred_flag = 1'b1;
        end
        next_crc_err_flag = crc_err_flag;
        if (status_read) begin
            next_crc_err_flag = 1'b0;
        end
        if (RX_CRC_FAIL_IN && mode[MD_RXCRC_EN]) begin
            next_crc_err_flag = 1'b1;
        end
        next_reset_flag = reset_flag;
        if (mode_write && !HWDATA_IN[MD_RESET]) begin
            next_reset_flag = 1'b0;
        end
        next_new_sample_flag = (new_sample_flag & ~SAMPLE_TAKEN_IN) | NEW_SAMPLE_IN;
    end

    // ************************************************************
    // register map checksum watch
    // ************************************************************
    always_comb begin
        crc_now = crc16_word(mode, mode[MD_CRC_TYPE]);
        next_crc_last = crc_last;
        next_crc_valid = crc_valid;
        next_regmap_flag = regmap_flag;
        if (status_read) begin
            next_regmap_flag = 1'b0;
        end
        if (mode[MD_REGCRC_EN]) begin
            next_crc_last = crc_now;
            next_crc_valid = 1'b1;
            if (crc_valid && crc_now != crc_last) begin
                next_regmap_flag = 1'b1;
            end
        end else begin
            next_crc_valid = 1'b0;
        end
    end

    // ************************************************************
    // output word formatting
    // ************************************************************
    always_comb begin
        case (adcsm_wlen_t'(mode[WLEN_LSB +: 2]))
            WLEN_16: next_word_out = {16'h0000, CONV_DATA_IN[23:8]};
            WLEN_24: next_word_out = {8'h00, CONV_DATA_IN};
            WLEN_32_ZPAD: next_word_out = {CONV_DATA_IN, 8'h00};
            default: next_word_out = {{8{CONV_DATA_IN[23]}}, CONV_DATA_IN};
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode <= MODE_RESET;
            lock_flag <= STATUS_RESET[ST_LOCK];
            resync_occurred_flag <= STATUS_RESET[ST_RESYNC];
            regmap_flag <= STATUS_RESET[ST_REGMAP];
            crc_err_flag <= STATUS_RESET[ST_CRC_ERR];
            reset_flag <= STATUS_RESET[ST_RESET];
            new_sample_flag <= '0;
            crc_last <= 16'h0000;
            crc_valid <= 1'b0;
            word_out <= '0;
        end else begin
            mode <= next_mode;
            lock_flag <= next_lock_flag;
            resync_occurred_flag <= next_resync_occurred_flag;
            regmap_flag <= next_regmap_flag;
            crc_err_flag <= next_crc_err_flag;
            reset_flag <= next_reset_flag;
            new_sample_flag <= next_new_sample_flag;
            crc_last <= next_crc_last;
            crc_valid <= next_crc_valid;
            word_out <= next_word_out;
        end
    end

    // ************************************************************
    // sample-ready pin
    // ************************************************************
    assign rdy.pending = new_sample_flag;
    assign rdy.arrived = NEW_SAMPLE_IN;
    assign rdy.enabled = CHANNEL_ENABLE_IN;
    assign rdy.source_select = mode[MD_SRC_LSB +: 2];
    assign rdy.idle_float = mode[MD_IDLE_FLOAT];
    assign rdy.pulse_format = mode[MD_PULSE_FMT];

    adcsm_ready_pin #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_ready_pin (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .rdy(rdy.pin)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    assign HRDATA_OUT = rdata;
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;
    assign TIMEOUT_ENABLE_OUT = mode[MD_TIMEOUT];
    assign RX_CRC_CHECK_OUT = mode[MD_RXCRC_EN];
    assign CRC_POLY_ANSI_OUT = mode[MD_CRC_TYPE];
    assign WORD_SIZE_OUT = mode[WLEN_LSB +: 2];
    assign FORMATTED_WORD_OUT = word_out;
    assign SAMPLE_READY_OUT = rdy.pin_level;
    assign SAMPLE_READY_OE_OUT = rdy.pin_oe;
endmodule

// ---- bench/adcsm_bank_assertions.sv ----
// concurrent checks on the ports of the status and mode register bank
module adcsm_bank_assertions
    import adcsm_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // bus
    input wire logic HSEL_IN,
    input wire logic [adcsm_pkg::BUS_W-1:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic [adcsm_pkg::BUS_W-1:0] HRDATA_OUT,
    // core side
    input wire logic LOCK_STATE_IN,
    input wire logic [23:0] CONV_DATA_IN,
    input wire logic TIMEOUT_ENABLE_OUT,
    input wire logic RX_CRC_CHECK_OUT,
    input wire logic CRC_POLY_ANSI_OUT,
    input wire logic [1:0] WORD_SIZE_OUT,
    input wire logic [adcsm_pkg::BUS_W-1:0] FORMATTED_WORD_OUT,
    input wire logic SAMPLE_READY_OUT,
    input wire logic SAMPLE_READY_OE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    logic take;
    logic rd_stat;
    logic rd_mode;
    assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN;
    assign rd_stat = take && (HADDR_IN == 32'h00000004);
    assign rd_mode = take && (HADDR_IN == 32'h00000008);
    property p_lock;
        rd_stat |=> HRDATA_OUT[15] == $past(LOCK_STATE_IN, 2);
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit wrong");
    property p_poly;
        rd_stat |=> HRDATA_OUT[11] == $past(CRC_POLY_ANSI_OUT);
    endproperty
    a_poly: assert property (p_poly) else $error("poly bit wrong");
    property p_wlen;
        rd_stat |=> HRDATA_OUT[9:8] == $past(WORD_SIZE_OUT);
    endproperty
    a_wlen: assert property (p_wlen) else $error("word size wrong");
    property p_tmo;
        rd_mode |=> HRDATA_OUT[4] == $past(TIMEOUT_ENABLE_OUT);
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout bit wrong");
    property p_rxcrc;
        rd_mode |=> HRDATA_OUT[12] == $past(RX_CRC_CHECK_OUT);
    endproperty
    a_rxcrc: assert property (p_rxcrc) else $error("input check bit wrong");
    property p_sext;
        WORD_SIZE_OUT == 2'h3 |=>
            FORMATTED_WORD_OUT == {{8{$past(CONV_DATA_IN[23])}}, $past(CONV_DATA_IN)};
    endproperty
    a_sext: assert property (p_sext) else $error("sign extension wrong");
    property p_zpad;
        WORD_SIZE_OUT == 2'h2 |=> FORMATTED_WORD_OUT == {$past(CONV_DATA_IN), 8'h00};
    endproperty
    a_zpad: assert property (p_zpad) else $error("zero padding wrong");
    property p_float;
        !SAMPLE_READY_OE_OUT |-> SAMPLE_READY_OUT;
    endproperty
    a_float: assert property (p_float) else $error("floating while low");
    property p_resv;
        rd_stat |=> HRDATA_OUT[31:16] == 16'h0000 && HRDATA_OUT[7:2] == 6'h00;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    c_stat: cover property (rd_stat);
    c_mode: cover property (rd_mode);
    c_low: cover property ($fell(SAMPLE_READY_OUT));
endmodule
bind adcsm_bank adcsm_bank_assertions u_adcsm_bank_assertions (.CLK_IN(CLK_IN),
    .RST_N_IN(RST_N_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN),
    .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
    .LOCK_STATE_IN(LOCK_STATE_IN), .CONV_DATA_IN(CONV_DATA_IN),
    .TIMEOUT_ENABLE_OUT(TIMEOUT_ENABLE_OUT), .RX_CRC_CHECK_OUT(RX_CRC_CHECK_OUT),
    .CRC_POLY_ANSI_OUT(CRC_POLY_ANSI_OUT), .WORD_SIZE_OUT(WORD_SIZE_OUT),
    .FORMATTED_WORD_OUT(FORMATTED_WORD_OUT), .SAMPLE_READY_OUT(SAMPLE_READY_OUT),
    .SAMPLE_READY_OE_OUT(SAMPLE_READY_OE_OUT));

// ---- bench/adcsm_host_model.sv ----
// bus master standing in for the host processor
module adcsm_host_model
    import adcsm_pkg::*;
(
    // clock and bus answer
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [adcsm_pkg::BUS_W-1:0] hrdata_in,
    // bus request
    output logic hsel_out,
    output logic [adcsm_pkg::BUS_W-1:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [adcsm_pkg::BUS_W-1:0] hwdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h00000000;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h00000000;
    end
    // one single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        logic [31:0] wd;
        wd = d & {16'h0000, MODE_WRITE_MASK};
        hsel_out <= 1'b1;
        haddr_out <= a;
        htrans_out <= 2'h2;
        hwrite_out <= wr;
        hwdata_out <= ~hwdata_out;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        hsel_out <= 1'b0;
        htrans_out <= 2'h0;
        hwdata_out <= wr ? wd : ~wd;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        q = hrdata_in;
    endtask
endmodule

// ---- bench/adcsm_bank_test.sv ----
// self-checking bench for the status and mode register bank
module adcsm_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsm_pkg::*;
    localparam int PC = 4;
    logic clk = 1'b0;
    logic rst_n;
    logic hsel, hwrite, hready, hresp, lock, resync, crc_fail, tmo, rxc, poly, rdy, rdy_oe;
    logic [1:0] htrans, wsz, new_smp, taken, ch_en;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, fword;
    logic [23:0] conv;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    // identity upper nibble and revision byte are arbitrary
    adcsm_bank #(.ID_UPPER(4'h5), .ID_REVISION(8'h3C), .PULSE_CYCLES(PC)) u_adcsm_bank (
        .CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .LOCK_STATE_IN(lock), .RESYNC_EVENT_IN(resync), .RX_CRC_FAIL_IN(crc_fail),
        .NEW_SAMPLE_IN(new_smp), .SAMPLE_TAKEN_IN(taken), .CHANNEL_ENABLE_IN(ch_en),
        .CONV_DATA_IN(conv), .TIMEOUT_ENABLE_OUT(tmo), .RX_CRC_CHECK_OUT(rxc),
        .CRC_POLY_ANSI_OUT(poly), .WORD_SIZE_OUT(wsz), .FORMATTED_WORD_OUT(fword),
        .SAMPLE_READY_OUT(rdy), .SAMPLE_READY_OE_OUT(rdy_oe));
    adcsm_host_model u_adcsm_host_model (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
        .hsize_out(hsize), .hwdata_out(hwdata));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [31:0] q;
        u_adcsm_host_model.xfer(1'b0, a, 32'h00000000, q);
        cmp(q & {16'hFFFF, m}, {16'h0000, e});
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic [31:0] q;
        u_adcsm_host_model.xfer(1'b1, a, {16'h0000, d}, q);
    endtask
    task automatic ev(input int k);
        @(posedge clk);
        case (k)
            0: resync <= 1'b1;
            1: crc_fail <= 1'b1;
            2: new_smp <= 2'h1;
            3: new_smp <= 2'h2;
            default: taken <= 2'h3;
        endcase
        @(posedge clk);
        resync <= 1'b0;
        crc_fail <= 1'b0;
        new_smp <= 2'h0;
        taken <= 2'h0;
    endtask
    task automatic pin(input logic e);
        for (int n = 0; n < 8 && rdy !== e; n++) @(posedge clk);
        cmp({31'h0, rdy}, {31'h0, e});
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        {rst_n, lock, resync, crc_fail, new_smp, taken} = '0;
        ch_en = 2'h3;
        conv = 24'h801234;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(32'h0, 16'hFF00, 16'h5200);
        rd(32'h4, 16'hFFFF, STATUS_RESET);
        rd(32'h8, 16'hFFFF, MODE_RESET);
        cmp({27'h0, tmo, rxc, poly, wsz}, 32'h11);
        cmp({30'h0, rdy, rdy_oe}, 32'h3);
        wr(32'h0, 16'hFFFF);
        wr(32'h4, 16'hFFFF);
        wr(32'h40, 16'hFFFF);
        rd(32'h0, 16'hFF00, 16'h5200);
        rd(32'h4, 16'hFFFF, STATUS_RESET);
        rd(32'h40, 16'hFFFF, 16'h0000);
        cmp({31'h0, hresp}, 32'h0);
        wr(32'h8, 16'h0510);
        rd(32'h4, 16'h0400, 16'h0400);
        wr(32'h8, 16'h0110);
        rd(32'h4, 16'h0400, 16'h0000);
        lock <= 1'b1;
        repeat (2) @(posedge clk);
        rd(32'h4, 16'h8000, 16'h8000);
        ev(0);
        rd(32'h4, 16'h4000, 16'h4000);
        ev(1);
        rd(32'h4, 16'h1000, 16'h0000);
        wr(32'h8, 16'h1110);
        ev(1);
        rd(32'h4, 16'h1000, 16'h1000);
        cmp({31'h0, rxc}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(32'h8, 16'h0010 | 16'(i << 8));
            rd(32'h4, 16'h2300, 16'(i << 8));
            cmp({30'h0, wsz}, i);
        end
        wr(32'h8, 16'h0910);
        rd(32'h4, 16'h0800, 16'h0800);
        cmp({31'h0, poly}, 32'h1);
        wr(32'h8, 16'h2910);
        repeat (3) @(posedge clk);
        rd(32'h4, 16'h2000, 16'h0000);
        wr(32'h8, 16'h2110);
        repeat (3) @(posedge clk);
        rd(32'h4, 16'h2000, 16'h2000);
        wr(32'h8, 16'h0110);
        ev(3);
        rd(32'h4, 16'h0003, 16'h0002);
        cmp({31'h0, rdy}, 32'h1);
        ev(2);
        rd(32'h4, 16'h0003, 16'h0003);
        pin(1'b0);
        ev(4);
        rd(32'h4, 16'h0003, 16'h0000);
        pin(1'b1);
        wr(32'h8, 16'h0114);
        ev(2);
        pin(1'b0);
        ev(4);
        wr(32'h8, 16'h0115);
        ev(3);
        pin(1'b0);
        pin(1'b1);
        rd(32'h4, 16'h0002, 16'h0002);
        ev(4);
        wr(32'h8, 16'h0118);
        ev(3);
        pin(1'b0);
        ev(4);
        wr(32'h8, 16'h0112);
        repeat (4) @(posedge clk);
        cmp({31'h0, rdy_oe}, 32'h0);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(32'h4, 16'h0400, 16'h0400);
        rd(32'h8, 16'hFFFF, MODE_RESET);
        stop_test();
    end
endmodule
